/* rtl/ssy_spi_cfg.svh */
// Offsets, field positions, reset values and bit-rate counts of the SPI port
`ifndef SSY_SPI_CFG_SVH
`define SSY_SPI_CFG_SVH

// Register indices; byte address is four times the index
`define SSY_IDX_INT_CTRL      8'h0b
`define SSY_IDX_PERIPH_FLAGS  8'h0c
`define SSY_IDX_SER_BUF       8'h13
`define SSY_IDX_SER_CTRL      8'h14
`define SSY_IDX_PORT_A_DIR    8'h85
`define SSY_IDX_PORT_C_DIR    8'h87
`define SSY_IDX_PERIPH_EN     8'h8c
`define SSY_IDX_SER_STAT      8'h94

// Serial control fields
`define SSY_CTRL_COLL_BIT     7
`define SSY_CTRL_OVF_BIT      6
`define SSY_CTRL_EN_BIT       5
`define SSY_CTRL_POL_BIT      4

// Serial status fields
`define SSY_STAT_SMPL_BIT     7
`define SSY_STAT_EDGE_BIT     6

// Flag and enable bit of the serial interrupt
`define SSY_IRQ_BIT           3

// Port direction bits used by the serial pins
`define SSY_DIR_SCK_BIT       6
`define SSY_DIR_SDO_BIT       4

// Mode field codes
`define SSY_MODE_MST_DIV4     4'h0
`define SSY_MODE_MST_DIV16    4'h1
`define SSY_MODE_MST_DIV64    4'h2
`define SSY_MODE_MST_TMR      4'h3
`define SSY_MODE_SLV_SEL      4'h4
`define SSY_MODE_SLV          4'h5

// Reset values
`define SSY_RST_ZERO          8'h00
`define SSY_RST_DIR           8'hff

// System clocks per serial clock half period, per divide ratio
`define SSY_HALF_DIV4         6'h02
`define SSY_HALF_DIV16        6'h08
`define SSY_HALF_DIV64        6'h20

// Half-period edges of one master byte
`define SSY_EDGES_BYTE        5'h10
`define SSY_EDGES_LATE        5'h11

`endif

/* rtl/ssy_pkg.sv */
// Types shared by the SPI port
package ssy_pkg;

  typedef enum logic [0:0]
  {
    SSY_IDLE  = 1'b0,
    SSY_SHIFT = 1'b1
  } ssy_phase_type;

  typedef struct packed
  {
    logic          ack;
    logic [7:0]    rdata;
    logic [7:0]    int_ctrl;
    logic [7:0]    periph_flags;
    logic [7:0]    periph_en;
    logic [7:0]    port_a_dir;
    logic [7:0]    port_c_dir;
    logic [7:0]    ctrl;
    logic          smpl;
    logic          clk_edge;
    logic          full;
    logic [7:0]    rx_buf;
    logic [7:0]    shreg;
    logic          sdo;
    logic          sck;
    ssy_phase_type phase;
    logic [4:0]    hcnt;
    logic [5:0]    div;
    logic [2:0]    bitcnt;
    logic          sck_m;
    logic          sck_s;
    logic          sck_p;
    logic          ss_m;
    logic          ss_s;
  } ssy_state_type;

endpackage : ssy_pkg

/* rtl/ssy_spi_port.sv */
// SPI master/slave serial port with Avalon-MM register access
//
// Chosen here: the Avalon-MM register port.
`include "ssy_spi_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Shift out on programmed edge, capture on opposite edge, or on the output edge with late sampling; full duplex.
// - Master and slave must share the same idle clock polarity.
// - Master may start a transfer at any time; it makes the clock.
// - Master starts shifting at once when the buffer is written.
// - Master keeps receiving with output disabled; bytes load buffer normally.
// - Control bit 4 selects the idle level of the serial clock.
// - Bytes go out most significant bit first.
// - Master rate is clock/4, /16, /64 or timer-two output/2.
// - With edge select set, output data is valid before first edge.
// - Sample-phase bit picks middle or end of output time for sampling.
// - SPI modes map to polarity/edge: 00=0,1 01=0,0 10=1,1 11=1,0.
// - Slave shifts on external clock, flags interrupt after last bit.
// - Slave keeps shifting during sleep; full byte sets flag and wakes.
// - Master freezes its transfer during sleep and resumes after wake.
// - Slave-select control works only in slave mode with code 4.
// - Low slave-select enables transfer and drives the serial output.
// - High slave-select stops driving serial output immediately, mid-byte too.
// - High slave-select resets the serial engine in slave-select mode.
// - Engine reset clears bit counter; by select high or enable clear.
// - Output pin set as input disables transmission from it.
// - Device reset disables the port and aborts any transfer.
// - Full byte moves to buffer, sets full and flag; read clears full.
// - Buffer write during transfer is ignored and sets sticky collision.
// - Slave byte arriving with buffer full sets overflow and is lost.
// - Mode codes 0 to 5 select the four master and two slave modes.
module ssy_spi_port
  import ssy_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_sleep,
  input  wire logic        i_timer_two_output,
  input  wire logic        i_sck,
  output logic             o_sck,
  output logic             o_sck_oe,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  input  wire logic        i_ss_n,
  output logic             o_serial_irq
);

  // Whole block state; one struct, one register
  ssy_state_type st;
  ssy_state_type next_st;

  // Decoded control and engine strobes
  logic       req;
  logic       accept;
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] wdata;
  logic [3:0] mode;
  logic       port_en;
  logic       pol;
  logic       is_master;
  logic       is_slave;
  logic       ss_ctl;
  logic       ss_hold;
  logic       busy;
  logic       buf_wr;
  logic [4:0] ecount;
  logic       out_edge;
  logic       smp_now;
  logic       out_now;
  logic [4:0] last_e;
  logic [5:0] half_len;
  logic       tick;
  logic       sck_edge;
  logic       sck_lead;
  logic       slv_run;
  logic       slv_sample;
  logic       slv_out;
  logic [7:0] shin;

  // Register read mux; unmapped indices read zero
  function automatic logic [7:0] read_reg(input ssy_state_type s,
                                          input logic [7:0]    idx);
    case (idx)
      `SSY_IDX_INT_CTRL:     read_reg = s.int_ctrl;
      `SSY_IDX_PERIPH_FLAGS: read_reg = s.periph_flags;
      `SSY_IDX_SER_BUF:      read_reg = s.rx_buf;
      `SSY_IDX_SER_CTRL:     read_reg = s.ctrl;
      `SSY_IDX_PORT_A_DIR:   read_reg = s.port_a_dir;
      `SSY_IDX_PORT_C_DIR:   read_reg = s.port_c_dir;
      `SSY_IDX_PERIPH_EN:    read_reg = s.periph_en;
      `SSY_IDX_SER_STAT:     read_reg = {s.smpl, s.clk_edge, 5'h00, s.full};
      default:               read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // One wait cycle, then the access is taken
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~st.ack;
  assign accept            = req & st.ack;
  assign wr_ok             = i_avs_write & accept & i_avs_byteenable[0];
  assign rd_ok             = i_avs_read & accept;
  assign wdata             = i_avs_writedata[7:0];
  assign o_avs_readdata    = {24'h000000, st.rdata};

  assign mode      = st.ctrl[3:0];
  assign port_en   = st.ctrl[`SSY_CTRL_EN_BIT];
  assign pol       = st.ctrl[`SSY_CTRL_POL_BIT];
  assign is_master = port_en && (mode <= `SSY_MODE_MST_TMR);
  assign is_slave  = port_en && ((mode == `SSY_MODE_SLV_SEL) ||
                                 (mode == `SSY_MODE_SLV));
  // select control only in code 4
  assign ss_ctl    = port_en && (mode == `SSY_MODE_SLV_SEL);
  // high select holds the engine in reset
  assign ss_hold   = ss_ctl && st.ss_s;
  // Slave mid-byte counts as busy so buffer writes collide
  assign busy      = (st.phase == SSY_SHIFT) || (st.bitcnt != 3'h0);
  assign buf_wr    = wr_ok && (i_avs_address == `SSY_IDX_SER_BUF);
  // Shift-in value shared by master and slave
  assign shin      = {st.shreg[6:0], i_sdi};

  // edge roles within a master byte; odd edges lead
  assign ecount   = st.hcnt + 5'h01;
  assign out_edge = ecount[0] ^ st.clk_edge;
  assign smp_now  = st.smpl ? (out_edge && (ecount > 5'h01)) : ~out_edge;
  assign out_now  = out_edge && (ecount <= `SSY_EDGES_BYTE);
  // Late sampling with leading-edge output needs one extra half period
  assign last_e   = (!st.clk_edge && st.smpl) ? `SSY_EDGES_LATE
                                              : `SSY_EDGES_BYTE;

  assign half_len = (mode == `SSY_MODE_MST_DIV4)  ? `SSY_HALF_DIV4  :
                    (mode == `SSY_MODE_MST_DIV16) ? `SSY_HALF_DIV16 :
                                                    `SSY_HALF_DIV64;
  assign tick = (st.phase == SSY_SHIFT) && !i_sleep &&
                ((mode == `SSY_MODE_MST_TMR) ? i_timer_two_output
                                             : (st.div == half_len - 6'h01));

  // slave edges come from the synchronised clock
  assign sck_edge   = st.sck_s ^ st.sck_p;
  assign sck_lead   = sck_edge && (st.sck_s != pol);
  assign slv_run    = is_slave && !ss_hold;
  // slave shifts on external edges, independent of sleep
  assign slv_sample = slv_run && sck_edge && (sck_lead == st.clk_edge);
  assign slv_out    = slv_run && sck_edge && (sck_lead != st.clk_edge);

  // Pin drivers
  assign o_sck        = st.sck;
  assign o_sck_oe     = is_master && !st.port_c_dir[`SSY_DIR_SCK_BIT];
  assign o_sdo        = st.sdo;
  // Raw select pin so the output lets go without sync delay
  // output drive follows direction bit and raw select
  assign o_sdo_oe     = port_en && !st.port_c_dir[`SSY_DIR_SDO_BIT] &&
                        !(ss_ctl && i_ss_n);
  assign o_serial_irq = st.periph_flags[`SSY_IRQ_BIT] &&
                        st.periph_en[`SSY_IRQ_BIT];

  // Next state; later assignments override earlier ones
  always_comb
  begin
    next_st       = st;
    // two sync flops, third finds edges
    next_st.sck_m = i_sck;
    next_st.sck_s = st.sck_m;
    next_st.sck_p = st.sck_s;
    next_st.ss_m  = i_ss_n;
    next_st.ss_s  = st.ss_m;
    // Ack alternates, giving one wait cycle per access
    next_st.ack   = req & ~st.ack;
    // Read data captured in the wait cycle
    if (req && !st.ack)
    begin
      next_st.rdata = read_reg(st, i_avs_address);
    end

    // Software writes first, so hardware sets below win
    if (wr_ok)
    begin
      case (i_avs_address)
        `SSY_IDX_INT_CTRL:     next_st.int_ctrl     = wdata;
        `SSY_IDX_PERIPH_FLAGS: next_st.periph_flags = wdata;
        `SSY_IDX_SER_CTRL:     next_st.ctrl         = wdata;
        `SSY_IDX_PORT_A_DIR:   next_st.port_a_dir   = wdata;
        `SSY_IDX_PORT_C_DIR:   next_st.port_c_dir   = wdata;
        `SSY_IDX_PERIPH_EN:    next_st.periph_en    = wdata;
        `SSY_IDX_SER_STAT:
        begin
          next_st.smpl     = wdata[`SSY_STAT_SMPL_BIT];
          next_st.clk_edge = wdata[`SSY_STAT_EDGE_BIT];
        end
        default:
        begin
          next_st.rdata = next_st.rdata;
        end
      endcase
    end
    if (rd_ok && (i_avs_address == `SSY_IDX_SER_BUF))
    begin
      next_st.full = 1'b0;
    end

    if (buf_wr && busy)
    begin
      // write during a transfer is dropped
      next_st.ctrl[`SSY_CTRL_COLL_BIT] = 1'b1;
    end
    else if (buf_wr && port_en)
    begin
      // first bit out before any clock edge
      next_st.shreg = wdata;
      next_st.sdo   = wdata[7];
    end

    case (st.phase)
      SSY_IDLE:
      begin
        next_st.sck  = pol;
        next_st.hcnt = 5'h00;
        next_st.div  = 6'h00;
        if (buf_wr && !busy && is_master)
        begin
          next_st.phase = SSY_SHIFT;
        end
      end
      SSY_SHIFT:
      begin
        if (tick)
        begin
          next_st.div  = 6'h00;
          next_st.hcnt = ecount;
          // No toggle on the extra late-sample tick
          if (ecount <= `SSY_EDGES_BYTE)
          begin
            next_st.sck = ~st.sck;
          end
          if (smp_now)
          begin
            next_st.shreg = shin;
          end
          if (out_now)
          begin
            next_st.sdo = smp_now ? st.shreg[6] : st.shreg[7];
          end
          // master byte always loads; no overflow in master
          if (ecount == last_e)
          begin
            next_st.rx_buf                    = smp_now ? shin : st.shreg;
            next_st.full                      = 1'b1;
            next_st.periph_flags[`SSY_IRQ_BIT] = 1'b1;
            next_st.phase                     = SSY_IDLE;
          end
        end
        else if (!i_sleep && (mode != `SSY_MODE_MST_TMR))
        begin
          // Divider counts to one half period
          next_st.div = st.div + 6'h01;
        end
        // Leaving master mode drops the byte
        if (!is_master)
        begin
          next_st.phase = SSY_IDLE;
        end
      end
      default:
      begin
        next_st.phase = SSY_IDLE;
      end
    endcase

    // engine reset by select high or port disable
    if (ss_hold || !port_en)
    begin
      next_st.bitcnt = 3'h0;
    end
    else if (slv_sample)
    begin
      next_st.shreg  = shin;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7)
      begin
        // flag once the last bit is latched
        next_st.periph_flags[`SSY_IRQ_BIT] = 1'b1;
        // unread buffer: byte lost, overflow set
        if (st.full)
        begin
          next_st.ctrl[`SSY_CTRL_OVF_BIT] = 1'b1;
        end
        else
        begin
          next_st.rx_buf = shin;
          next_st.full   = 1'b1;
        end
      end
    end
    else if (slv_out)
    begin
      // Slave drives next bit on its output edge
      next_st.sdo = st.shreg[7];
    end

    if (!port_en)
    begin
      next_st.phase = SSY_IDLE;
    end
  end

  // device reset disables the port and ends any transfer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st            <= '0;
      st.port_a_dir <= `SSY_RST_DIR;
      st.port_c_dir <= `SSY_RST_DIR;
      st.ctrl       <= `SSY_RST_ZERO;
      st.phase      <= SSY_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : ssy_spi_port

`default_nettype wire

/* dv/ssy_spi_port_props.sv */
// Checker of pin and bus relations of the SPI port
`timescale 1ns/100ps
`default_nettype none
module ssy_spi_port_props
  import ssy_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_ss_n,
  input wire logic        o_sck,
  input wire logic        o_sck_oe,
  input wire logic        o_sdo_oe,
  input wire logic        o_serial_irq
);
  logic [7:0] ctl;
  logic [7:0] dir;
  logic       tk;
  logic       sl;
  logic       m0;
  logic       sck_q;
  assign tk = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign sl = ctl[5] && ctl[3:0] == 4'h4;
  assign m0 = o_sck && !sck_q && o_sck_oe && !ctl[4];
  // Shadow of the software-owned control and direction bits
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      ctl   <= 8'h00;
      dir   <= 8'hff;
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= o_sck;
      if (tk && i_avs_address == 8'h14)
        ctl <= i_avs_writedata[7:0];
      else if (tk && i_avs_address == 8'h87)
        dir <= i_avs_writedata[7:0];
    end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_sdo_dir; o_sdo_oe |-> !dir[4]; endproperty
  a_sdo_dir: assert property (p_sdo_dir) else $error("sdo on input");
  property p_ss_off; sl && i_ss_n |-> !o_sdo_oe; endproperty
  a_ss_off: assert property (p_ss_off) else $error("sdo kept");
  property p_ss_on; sl && !dir[4] && !i_ss_n |-> o_sdo_oe; endproperty
  a_ss_on: assert property (p_ss_on) else $error("sdo idle");
  property p_sck_dir; o_sck_oe |-> ctl[5] && ctl[3:0] < 4'h4 && !dir[6];
  endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("sck drive");
  property p_idle; o_sck_oe && o_sck != ctl[4] |-> ##[1:40] o_sck == ctl[4];
  endproperty
  a_idle: assert property (p_idle) else $error("sck idle level");
  property p_div4; m0 && ctl[3:0] == 4'h0 |-> ##2 $fell(o_sck); endproperty
  a_div4: assert property (p_div4) else $error("rate /4");
  property p_div16; m0 && ctl[3:0] == 4'h1 |-> ##8 $fell(o_sck); endproperty
  a_div16: assert property (p_div16) else $error("rate /16");
  property p_div64; m0 && ctl[3:0] == 4'h2 |-> ##32 $fell(o_sck); endproperty
  a_div64: assert property (p_div64) else $error("rate /64");
  property p_rst;
    disable iff (1'b0) !i_rst_n |-> !o_sck_oe && !o_sdo_oe && !o_serial_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("pins in reset");
  c_m0: cover property (m0 && ctl[3:0] == 4'h0);
  c_ss: cover property (sl && $rose(i_ss_n));
  c_slv: cover property (o_sdo_oe && !o_sck_oe);
endmodule : ssy_spi_port_props
bind ssy_spi_port ssy_spi_port_props u_ssy_spi_port_props (.*);
`default_nettype wire

/* dv/ssy_spi_partner.sv */
// Far-side SPI party: slave to the port's clock or master of its own
`timescale 1ns/100ps
`default_nettype none
module ssy_spi_partner
(
  input  wire logic i_clk,
  input  wire logic i_sck,
  input  wire logic i_sdo,
  output logic      o_sdi,
  output logic      o_sck,
  output logic      o_ss_n
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic       c;
  initial
  begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
  end
  // out on fall, in on rise, msb first
  assign c = o_sck | i_sck;
  assign o_sdi = tx[7];
  always @(posedge c)
    rx <= {rx[6:0], i_sdo};
  always @(negedge c)
    tx <= {tx[6:0], ~tx[0]};
  task put(input logic [7:0] d);
    tx = d;
  endtask : put
  // clock only inside a selected frame
  task send(input logic [7:0] d, input int nb);
    @(posedge i_clk);
    tx <= d;
    o_ss_n <= 1'b0;
    repeat (nb)
    begin
      repeat (6) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_sck <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    o_ss_n <= 1'b1;
  endtask : send
endmodule : ssy_spi_partner
`default_nettype wire

/* dv/tb_ssy_spi_port.sv */
// Self-checking bench of the SPI port against a far-side party
`timescale 1ns/100ps
`default_nettype none
module tb_ssy_spi_port;
  import ssy_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        slp = 1'b0;
  logic [1:0]  tc = 2'h0;
  logic [31:0] rdat;
  logic [7:0]  v;
  logic        tmr, wreq, sck, sck_oe, sdo, sdo_oe, irq, sdi, psck, pss, sdo_w;
  int          n_fail = 0;
  int          tests_run = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) tc <= tc + 2'h1;
  assign tmr = tc == 2'h3;
  assign sdo_w = sdo_oe ? sdo : ~sdo;
  ssy_spi_port u_ssy_spi_port (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'h1),
    .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_sleep(slp), .i_timer_two_output(tmr),
    .i_sck(psck), .o_sck(sck), .o_sck_oe(sck_oe), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_ss_n(pss), .o_serial_irq(irq));
  ssy_spi_partner u_ssy_spi_partner (
    .i_clk(clk), .i_sck(sck & sck_oe), .i_sdo(sdo_w), .o_sdi(sdi),
    .o_sck(psck), .o_ss_n(pss));
  task final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task tmo;
    chk("wait bound", 8'h01, 8'h00);
    final_report;
  endtask : tmo
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    if (k >= 20)
      tmo;
    v = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task wfull;
    int k;
    k = 0;
    do
    begin
      bus(1'b0, 8'h94, 8'h00);
      k++;
    end
    while (v[0] !== 1'b1 && k < 300);
    if (k >= 300)
      tmo;
  endtask : wfull
  task t_rst;
    logic [7:0] a [8] = '{8'h0c, 8'h13, 8'h14, 8'h85, 8'h87, 8'h8c, 8'h94,
                          8'h20};
    logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
                          8'h00};
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, a[i], 8'h00);
      chk("reset value", e[i], v);
    end
    $display("reset test done");
  endtask : t_rst
  task t_master;
    bus(1'b1, 8'h87, 8'haf);
    bus(1'b1, 8'h94, 8'h40);
    bus(1'b1, 8'h8c, 8'h08);
    bus(1'b1, 8'h14, 8'h20);
    u_ssy_spi_partner.put(8'h3c);
    bus(1'b1, 8'h13, 8'ha5);
    @(negedge clk);
    chk("first sdo", 8'h01, {7'h0, sdo});
    bus(1'b1, 8'h13, 8'h5a);
    wfull;
    chk("irq", 8'h01, {7'h0, irq});
    bus(1'b0, 8'h13, 8'h00);
    chk("rx byte", 8'h3c, v);
    chk("wire byte", 8'ha5, u_ssy_spi_partner.rx);
    bus(1'b0, 8'h94, 8'h00);
    chk("full cleared", 8'h40, v);
    bus(1'b0, 8'h14, 8'h00);
    chk("collision", 8'ha0, v);
    $display("master test done");
  endtask : t_master
  task t_rates;
    logic s;
    for (int m = 1; m < 4; m++)
    begin
      bus(1'b1, 8'h87, m == 1 ? 8'hbf : 8'haf);
      bus(1'b1, 8'h14, m == 3 ? 8'h33 : 8'h20 | m[7:0]);
      u_ssy_spi_partner.put(8'h81 + m[7:0]);
      bus(1'b1, 8'h13, 8'h42);
      chk("sdo enable", {7'h0, m != 1}, {7'h0, sdo_oe});
      if (m == 3)
      begin
        repeat (12) @(posedge clk);
        slp <= 1'b1;
        @(negedge clk) s = sck;
        repeat (20) @(negedge clk);
        chk("frozen sck", {7'h0, s}, {7'h0, sck});
        @(posedge clk) slp <= 1'b0;
      end
      wfull;
      bus(1'b0, 8'h13, 8'h00);
      chk("rate byte", 8'h81 + m[7:0], v);
      if (m == 3)
        chk("idle high", 8'h01, {7'h0, sck});
    end
    $display("rate test done");
  endtask : t_rates
  task t_slave;
    bus(1'b1, 8'h87, 8'hef);
    bus(1'b1, 8'h14, 8'h24);
    bus(1'b1, 8'h0c, 8'h00);
    bus(1'b1, 8'h13, 8'hc3);
    u_ssy_spi_partner.send(8'h99, 3);
    @(negedge clk);
    chk("released sdo", 8'h00, {7'h0, sdo_oe});
    u_ssy_spi_partner.send(8'h66, 8);
    u_ssy_spi_partner.send(8'h18, 8);
    bus(1'b0, 8'h0c, 8'h00);
    chk("slave flag", 8'h08, v);
    bus(1'b0, 8'h14, 8'h00);
    chk("overflow", 8'h64, v);
    bus(1'b0, 8'h13, 8'h00);
    chk("slave byte", 8'h66, v);
    $display("slave test done");
  endtask : t_slave
  task t_abort;
    bus(1'b1, 8'h87, 8'haf);
    bus(1'b1, 8'h14, 8'h22);
    bus(1'b1, 8'h13, 8'h77);
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("sck released", 8'h00, {7'h0, sck_oe});
    bus(1'b0, 8'h14, 8'h00);
    chk("port disabled", 8'h00, v);
    $display("abort test done");
  endtask : t_abort
  initial
  begin
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_rst;
    t_master;
    t_rates;
    t_slave;
    t_abort;
    final_report;
  end
endmodule : tb_ssy_spi_port
`default_nettype wire
